// [sas_arb_sel.sv]
// scsi arbitration and selection sequencer with axi4-lite register slave
//
// Functional notes
// [R1] mode 00 simple, 11 full, others reserved
// [R2] simple: await bus free, drive busy, id
// [R3] simple: select seen, release, set lost
// [R4] software reads bus lines after arbitration delay
// [R5] software asserts select, waits settle delay; no register lets software drive select, only the full sequence drives it
// [R6] full: await bus free, drive busy, id
// [R7] full: lose on select or higher id, retry
// [R8] full: retry until won, set won flag
// [R9] after win, drive select, target, own id
// [R10] selection complete sets function-complete flag
// [R11] selection timeout sets selection time-out flag
// [R12] start bit launches sequence of chosen mode
// [R13] hardware clears start bit when finished
// [R14] software avoids start while connected
// [R15] software checks connected after aborted sequence
// [R16] start bit from software or script processor
// [R17] connected flag set after arbitration or selection
// [R18] reset: full mode, start clear; reserved inert
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sas_arb_sel #(
   parameter int SEL_TIMEOUT = sas_pkg::SEL_TIMEOUT_CYC
) (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // axi4-lite write address and data
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // script processor start request
   input  wire logic        scriptStart,
   // scsi bus, asserted level is 1
   input  wire logic        busyLineIn,
   output logic             busyLineOut,
   output logic             busyLineOe,
   input  wire logic        selectIn,
   output logic             selectOut,
   output logic             selectOe,
   input  wire logic [15:0] dataLinesIn,
   output logic [15:0]      dataLinesOut,
   output logic [15:0]      dataLinesOe,
   // interrupt
   output logic             irq
);
   import sas_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      sas_state_t       st;
      logic [7:0]       ctl0;
      logic             connected_flag;
      logic [7:0]       ownId;
      logic [7:0]       destId;
      logic [7:0]       stat0;
      logic [7:0]       ist0;
      logic [7:0]       ist1;
      logic [7:0]       mask0;
      logic [7:0]       mask1;
      logic             busy;
      logic             sel;
      logic [15:0]      dataOut;
      logic             awHave;
      logic [11:0]      awAddr;
      logic             wHave;
      logic [31:0]      wData;
      logic [3:0]       wStrb;
      logic             bValid;
      logic [1:0]       bResp;
      logic             rValid;
      logic [31:0]      rData;
      logic [1:0]       rResp;
      logic             tmrLoad;
      logic [TMR_W-1:0] tmrCount;
   } sas_regs_t;

   sas_regs_t cur_ff;
   sas_regs_t nxt_cur;
   sas_tmr_if tmrBus ();

   // ---------------------------------------------------------------
   // delay timer
   // ---------------------------------------------------------------
   sas_timer u_timer (
      .clock (clock),
      .rst   (rst),
      .tmr   (tmrBus.tmr)
   );

   assign tmrBus.load  = cur_ff.tmrLoad;
   assign tmrBus.count = cur_ff.tmrCount;

   // ---------------------------------------------------------------
   // decoded helpers
   // ---------------------------------------------------------------
   logic [1:0]  arbMode;
   logic [15:0] ownBit;
   logic [15:0] destBit;
   logic [15:0] higherIds;
   logic        busFree;
   logic [11:0] wIdx;
   logic [11:0] rIdx;

   assign arbMode   = cur_ff.ctl0[CTL0_MODE_LO +: 2];
   assign ownBit    = 16'h0001 << cur_ff.ownId[ID_HI:ID_LO];
   assign destBit   = 16'h0001 << cur_ff.destId[ID_HI:ID_LO];
   // every id bit above our own has higher priority
   assign higherIds = ~((ownBit << 1) - 16'h0001);
   assign busFree   = !busyLineIn && !selectIn;
   assign wIdx      = {2'h0, cur_ff.awAddr[11:2]};
   assign rIdx      = {2'h0, s_axi_araddr[11:2]};

   // ---------------------------------------------------------------
   // next state: registers, bus slave and sequencer
   // ---------------------------------------------------------------
   always_comb begin
      logic [7:0] wb;
      logic       doWrite;
      logic [7:0] setIst0;
      logic [7:0] setIst1;
      wb      = cur_ff.wData[7:0];
      doWrite = cur_ff.awHave && cur_ff.wHave && !cur_ff.bValid;
      setIst0 = 8'h00;
      setIst1 = 8'h00;
      nxt_cur = cur_ff;
      nxt_cur.tmrLoad = 1'b0;

      // write channel capture, address and data in any order
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_cur.awHave = 1'b1;
         nxt_cur.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_cur.wHave = 1'b1;
         nxt_cur.wData = s_axi_wdata;
         nxt_cur.wStrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         nxt_cur.bValid = 1'b0;
      end

      // register write, only the low byte lane carries data
      if (doWrite) begin
         nxt_cur.awHave = 1'b0;
         nxt_cur.wHave  = 1'b0;
         nxt_cur.bValid = 1'b1;
         nxt_cur.bResp  = RESP_OKAY;
         if (wIdx == IDX_CTL0) begin
            if (cur_ff.wStrb[0]) nxt_cur.ctl0 = wb; // see [R16]
         end else if (wIdx == IDX_CTL1) begin
            if (cur_ff.wStrb[0]) nxt_cur.connected_flag = wb[CTL1_CON];
         end else if (wIdx == IDX_OWNID) begin
            if (cur_ff.wStrb[0]) nxt_cur.ownId = wb;
         end else if (wIdx == IDX_DESTID) begin
            if (cur_ff.wStrb[0]) nxt_cur.destId = wb;
         end else if (wIdx == IDX_STAT0) begin
            if (cur_ff.wStrb[0]) nxt_cur.stat0 = cur_ff.stat0 & ~wb;
         end else if (wIdx == IDX_MASK0) begin
            if (cur_ff.wStrb[0]) nxt_cur.mask0 = wb;
         end else if (wIdx == IDX_MASK1) begin
            if (cur_ff.wStrb[0]) nxt_cur.mask1 = wb;
         end else if (wIdx == IDX_IST0) begin
            if (cur_ff.wStrb[0]) nxt_cur.ist0 = cur_ff.ist0 & ~wb;
         end else if (wIdx == IDX_IST1) begin
            if (cur_ff.wStrb[0]) nxt_cur.ist1 = cur_ff.ist1 & ~wb;
         end else if (wIdx != IDX_BUSVIEW) begin
            nxt_cur.bResp = RESP_SLVERR;
         end
      end

      // script processor may also raise the start bit
      if (scriptStart) nxt_cur.ctl0[CTL0_START] = 1'b1; // see [R16]

      // read channel, one cycle from address to data
      if (s_axi_rvalid && s_axi_rready) nxt_cur.rValid = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_cur.rValid = 1'b1;
         nxt_cur.rResp  = RESP_OKAY;
         nxt_cur.rData  = 32'h0000_0000;
         if (rIdx == IDX_CTL0) begin
            nxt_cur.rData[7:0] = cur_ff.ctl0;
         end else if (rIdx == IDX_CTL1) begin
            nxt_cur.rData[CTL1_CON] = cur_ff.connected_flag;
         end else if (rIdx == IDX_OWNID) begin
            nxt_cur.rData[7:0] = cur_ff.ownId;
         end else if (rIdx == IDX_DESTID) begin
            nxt_cur.rData[7:0] = cur_ff.destId;
         end else if (rIdx == IDX_STAT0) begin
            nxt_cur.rData[7:0] = cur_ff.stat0;
         end else if (rIdx == IDX_MASK0) begin
            nxt_cur.rData[7:0] = cur_ff.mask0;
         end else if (rIdx == IDX_MASK1) begin
            nxt_cur.rData[7:0] = cur_ff.mask1;
         end else if (rIdx == IDX_IST0) begin
            nxt_cur.rData[7:0] = cur_ff.ist0;
         end else if (rIdx == IDX_IST1) begin
            nxt_cur.rData[7:0] = cur_ff.ist1;
         end else if (rIdx == IDX_BUSVIEW) begin
            nxt_cur.rData[15:0] = dataLinesIn; // see [R4]
         end else begin
            nxt_cur.rResp = RESP_SLVERR;
         end
      end

      // arbitration and selection sequencer
      case (cur_ff.st)
         SAS_IDLE: begin
            if (cur_ff.ctl0[CTL0_START]) begin
               if (arbMode == MODE_SIMPLE || arbMode == MODE_FULL) begin // see [R1] [R12]
                  nxt_cur.st    = SAS_WAIT_FREE;
                  nxt_cur.stat0 = cur_ff.stat0 & ~((8'h01 << STAT0_WON) | (8'h01 << STAT0_LOST));
               end else begin
                  nxt_cur.ctl0[CTL0_START] = 1'b0; // see [R18]
               end
            end
         end
         SAS_WAIT_FREE: begin
            if (busFree) begin // see [R2] [R6]
               nxt_cur.st       = SAS_ARB;
               nxt_cur.busy     = 1'b1;
               nxt_cur.dataOut  = ownBit;
               nxt_cur.tmrLoad  = 1'b1;
               nxt_cur.tmrCount = TMR_W'(ARB_DELAY_CYC);
            end
         end
         SAS_ARB: begin
            if (selectIn) begin
               nxt_cur.busy    = 1'b0;
               nxt_cur.dataOut = 16'h0000;
               if (arbMode == MODE_SIMPLE) begin
                  nxt_cur.stat0[STAT0_LOST] = 1'b1; // see [R3]
                  nxt_cur.ctl0[CTL0_START]  = 1'b0; // see [R13]
                  nxt_cur.st = SAS_IDLE;
               end else begin
                  nxt_cur.st = SAS_WAIT_FREE; // see [R7]
               end
            end else if (tmrBus.expired) begin
               if (arbMode == MODE_SIMPLE) begin
                  // software still checks the bus lines itself
                  nxt_cur.connected_flag = ((dataLinesIn & higherIds) == 16'h0000) ? 1'b1 : cur_ff.connected_flag; // see [R17]
                  nxt_cur.ctl0[CTL0_START] = 1'b0; // see [R13]
                  nxt_cur.st = SAS_SIMPLE_HOLD;
               end else if ((dataLinesIn & higherIds) != 16'h0000) begin
                  nxt_cur.busy    = 1'b0; // see [R7]
                  nxt_cur.dataOut = 16'h0000;
                  nxt_cur.st      = SAS_WAIT_FREE;
               end else begin
                  nxt_cur.stat0[STAT0_WON] = 1'b1; // see [R8]
                  nxt_cur.connected_flag      = 1'b1; // see [R17]
                  nxt_cur.sel      = 1'b1; // see [R9]
                  nxt_cur.dataOut  = ownBit | destBit;
                  nxt_cur.tmrLoad  = 1'b1;
                  nxt_cur.tmrCount = TMR_W'(ARB_DELAY_CYC);
                  nxt_cur.st       = SAS_SEL_SETTLE;
               end
            end
         end
         SAS_SIMPLE_HOLD: begin
            // busy stays driven until the connected flag is clear
            if (!cur_ff.connected_flag) begin
               nxt_cur.busy    = 1'b0;
               nxt_cur.dataOut = 16'h0000;
               nxt_cur.st      = SAS_IDLE;
            end
         end
         SAS_SEL_SETTLE: begin
            if (tmrBus.expired) begin
               nxt_cur.busy     = 1'b0; // target answers by raising busy
               nxt_cur.tmrLoad  = 1'b1;
               nxt_cur.tmrCount = TMR_W'(SEL_TIMEOUT);
               nxt_cur.st       = SAS_SEL_WAIT;
            end
         end
         SAS_SEL_WAIT: begin
            if (busyLineIn && !cur_ff.tmrLoad) begin
               setIst0[IST0_FUNC_DONE] = 1'b1; // see [R10]
               nxt_cur.sel     = 1'b0;
               nxt_cur.dataOut = 16'h0000;
               nxt_cur.ctl0[CTL0_START] = 1'b0; // see [R13]
               nxt_cur.st      = SAS_IDLE;
            end else if (tmrBus.expired) begin
               setIst1[IST1_SEL_TMO] = 1'b1; // see [R11]
               nxt_cur.sel     = 1'b0;
               nxt_cur.dataOut = 16'h0000;
               nxt_cur.connected_flag     = 1'b0;
               nxt_cur.ctl0[CTL0_START] = 1'b0; // see [R13]
               nxt_cur.st      = SAS_IDLE;
            end
         end
         default: nxt_cur.st = SAS_IDLE;
      endcase

      // hardware set wins over a write-one clear in the same cycle
      nxt_cur.ist0 = nxt_cur.ist0 | setIst0;
      nxt_cur.ist1 = nxt_cur.ist1 | setIst1;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         cur_ff      <= '0;
         cur_ff.st   <= SAS_IDLE;
         cur_ff.ctl0 <= CTL0_RESET; // see [R18]
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // one transaction at a time: hold address and data until the response is taken
   assign s_axi_awready = !cur_ff.awHave && !cur_ff.bValid;
   assign s_axi_wready  = !cur_ff.wHave && !cur_ff.bValid;
   assign s_axi_bvalid  = cur_ff.bValid;
   assign s_axi_bresp   = cur_ff.bResp;
   assign s_axi_arready = !cur_ff.rValid;
   assign s_axi_rvalid  = cur_ff.rValid;
   assign s_axi_rdata   = cur_ff.rData;
   assign s_axi_rresp   = cur_ff.rResp;

   // open-drain style: drive only the asserted lines
   assign busyLineOut  = cur_ff.busy;
   assign busyLineOe   = cur_ff.busy;
   assign selectOut    = cur_ff.sel;
   assign selectOe     = cur_ff.sel;
   assign dataLinesOut = cur_ff.dataOut;
   assign dataLinesOe  = cur_ff.dataOut;

   assign irq = |((cur_ff.ist0 & cur_ff.mask0) | (cur_ff.ist1 & cur_ff.mask1));

endmodule : sas_arb_sel

// [sas_pkg.sv]
// constants, register map and types of the scsi arbitration and selection block
package sas_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int ARB_DELAY_NS     = 2400;
   localparam int ARB_DELAY_CYC    = (ARB_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEL_TIMEOUT_MS   = 250;
   localparam int SEL_TIMEOUT_CYC  = SEL_TIMEOUT_MS * (1000000000 / CLK_PERIOD_PS);
   localparam int TMR_W            = 26;

   // ---------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_CTL0    = 12'h000;
   localparam logic [11:0] IDX_CTL1    = 12'h001;
   localparam logic [11:0] IDX_OWNID   = 12'h004;
   localparam logic [11:0] IDX_DESTID  = 12'h006;
   localparam logic [11:0] IDX_STAT0   = 12'h00d;
   localparam logic [11:0] IDX_MASK0   = 12'h040;
   localparam logic [11:0] IDX_MASK1   = 12'h041;
   localparam logic [11:0] IDX_IST0    = 12'h042;
   localparam logic [11:0] IDX_IST1    = 12'h043;
   localparam logic [11:0] IDX_BUSVIEW = 12'h058;

   // ---------------------------------------------------------------
   // fields and reset values
   // ---------------------------------------------------------------
   localparam int CTL0_START      = 5;
   localparam int CTL0_MODE_LO    = 6;
   localparam int CTL1_CON        = 4;
   localparam int STAT0_WON       = 2;
   localparam int STAT0_LOST      = 3;
   localparam int IST0_FUNC_DONE  = 6;
   localparam int IST1_SEL_TMO    = 2;
   localparam int ID_LO           = 0;
   localparam int ID_HI           = 3;
   localparam logic [7:0] CTL0_RESET = 8'hc0;
   localparam logic [1:0] MODE_SIMPLE = 2'h0;
   localparam logic [1:0] MODE_FULL   = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      SAS_IDLE, SAS_WAIT_FREE, SAS_ARB, SAS_SIMPLE_HOLD, SAS_SEL_SETTLE, SAS_SEL_WAIT
   } sas_state_t;

endpackage : sas_pkg

// [sas_tmr_if.sv]
// load and expiry signals between the sequencer and its delay timer
`timescale 1ns/1ps
interface sas_tmr_if;
   import sas_pkg::*;
   logic             load;
   logic [TMR_W-1:0] count;
   logic             expired;
   modport ctrl (output load, output count, input expired);
   modport tmr  (input load, input count, output expired);
endinterface : sas_tmr_if

// [sas_timer.sv]
// down-counting delay timer used for arbitration delay and selection time-out
`timescale 1ns/1ps
module sas_timer (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // control
   sas_tmr_if.tmr   tmr
);
   import sas_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] remain;
      logic             expired;
   } sas_tmr_state_t;

   sas_tmr_state_t cur_ff;
   sas_tmr_state_t nxt_cur;

   // load wins over counting so a restart always gets the full delay
   always_comb begin
      nxt_cur = cur_ff;
      // expiry is a one-cycle pulse, a stale level would end the next delay at once
      nxt_cur.expired = 1'b0;
      if (tmr.load) begin
         nxt_cur.remain  = tmr.count;
      end else if (cur_ff.remain != '0) begin
         nxt_cur.remain  = cur_ff.remain - 1'b1;
         nxt_cur.expired = (cur_ff.remain == TMR_W'(1));
      end
   end

   // state register
   always_ff @(posedge clock) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign tmr.expired = cur_ff.expired;

endmodule : sas_timer

// [sas_arb_sel_asserts.sv]
// port-level assertions of the arbitration and selection sequencer
`timescale 1ns/1ps
module sas_arb_sel_asserts #(
   parameter int SEL_TIMEOUT = 200
) (
   // clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // register bus handshakes
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   // scsi bus and interrupt
   input wire logic        busyLineIn,
   input wire logic        busyLineOe,
   input wire logic        selectIn,
   input wire logic        selectOe,
   input wire logic [15:0] dataLinesOe,
   input wire logic        irq
);
   logic [9:0]  arbCnt_ff, nxt_arbCnt;
   logic [15:0] selCnt_ff, nxt_selCnt;
   // ----------
   // counters and assertions
   // ----------
   // 600 cycles is too long to repeat, so it is counted
   always_comb begin
      nxt_arbCnt = (busyLineOe && !selectOe) ? arbCnt_ff + 10'h1 : 10'h0;
      nxt_selCnt = (selectOe && !busyLineOe) ? selCnt_ff + 16'h1 : 16'h0;
   end
   // run lengths
   always_ff @(posedge clock) begin
      arbCnt_ff <= rst ? 10'h0 : nxt_arbCnt;
      selCnt_ff <= rst ? 16'h0 : nxt_selCnt;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_lose; busyLineOe && !selectOe && selectIn; endsequence
   sequence s_settle; (busyLineOe && selectOe) [*8]; endsequence
   a_reset_quiet: assert property ($fell(rst) |-> !busyLineOe && !selectOe && !irq && dataLinesOe == 16'h0)
      else $error("bus or irq after reset");
   a_claim_on_free: assert property ($rose(busyLineOe) |-> $past(!busyLineIn && !selectIn))
      else $error("busy on busy bus");
   a_lose_release: assert property (s_lose |=> !busyLineOe)
      else $error("busy kept after select");
   a_single_id: assert property (busyLineOe && !selectOe |-> $onehot(dataLinesOe))
      else $error("not one id");
   a_arb_delay: assert property ($rose(selectOe) |-> arbCnt_ff >= 10'h256 && arbCnt_ff <= 10'h25a)
      else $error("short arbitration");
   a_select_settle: assert property ($rose(selectOe) |-> busyLineOe ##1 s_settle)
      else $error("busy dropped early");
   a_sel_timeout: assert property (selCnt_ff <= SEL_TIMEOUT + 3)
      else $error("select past time-out");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read late");
   a_write_hold: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken too early");
endmodule : sas_arb_sel_asserts
bind sas_arb_sel sas_arb_sel_asserts #(.SEL_TIMEOUT(SEL_TIMEOUT)) u_asserts (
   .clock, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .busyLineIn, .busyLineOe, .selectIn, .selectOe, .dataLinesOe, .irq
);

// [sas_bus_model.sv]
// one other initiator (id 7) and one target sharing the scsi bus with the sequencer
`timescale 1ns/1ps
module sas_bus_model (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // scenario controls
   input  wire logic        rivalArb,
   input  wire logic        rivalSel,
   input  wire logic        tgtOn,
   input  wire logic [3:0]  tgtId,
   // device drive
   input  wire logic        busyLineOut,
   input  wire logic        busyLineOe,
   input  wire logic        selectOut,
   input  wire logic        selectOe,
   input  wire logic [15:0] dataLinesOut,
   input  wire logic [15:0] dataLinesOe,
   // resolved bus, asserted level is 1
   output logic             busyLineIn,
   output logic             selectIn,
   output logic [15:0]      dataLinesIn,
   output logic [7:0]       claims
);
   logic       devBusy, devSel, rivalAct, tgtBusy_ff, rivalDone_ff, lastBusy_ff;
   logic [9:0] rivalCnt_ff;
   logic [5:0] tgtCnt_ff;
   logic [7:0] claims_ff;
   // wired-or bus; released lines read deasserted
   assign devBusy     = busyLineOut & busyLineOe;
   assign devSel      = selectOut & selectOe;
   assign rivalAct    = rivalCnt_ff != 10'h0;
   assign busyLineIn  = devBusy | rivalAct | tgtBusy_ff;
   assign selectIn    = devSel | (rivalAct & rivalSel);
   assign dataLinesIn = (dataLinesOut & dataLinesOe) | (rivalAct ? 16'h0080 : 16'h0000);
   assign claims      = claims_ff;
   // one rival per scenario; target answers once busy drops
   always_ff @(posedge clock) begin
      if (rst) begin
         {tgtBusy_ff, rivalDone_ff, lastBusy_ff} <= 3'h0;
         rivalCnt_ff <= 10'h0;
         tgtCnt_ff <= 6'h0;
         claims_ff <= 8'h0;
      end else begin
         lastBusy_ff <= devBusy;
         claims_ff <= claims_ff + {7'h0, devBusy & !lastBusy_ff};
         rivalDone_ff <= (rivalArb | rivalSel) & (rivalDone_ff | rivalAct);
         if (rivalAct) begin
            rivalCnt_ff <= rivalCnt_ff - 10'h1;
         end else if ((rivalArb | rivalSel) && !rivalDone_ff && devBusy && !devSel) begin
            rivalCnt_ff <= 10'h320;
         end
         tgtCnt_ff <= (tgtOn && devSel && dataLinesOut[tgtId] && dataLinesOe[tgtId] && !devBusy) ?
                      tgtCnt_ff + 6'h1 : 6'h0;
         if (tgtCnt_ff == 6'h28) begin
            tgtBusy_ff <= 1'b1;
         end else if (!devSel) begin
            tgtBusy_ff <= 1'b0;
         end
      end
   end
endmodule : sas_bus_model

// [sas_arb_sel_tb.sv]
// self-checking bench of the arbitration and selection sequencer
`timescale 1ns/1ps
module sas_arb_sel_tb;
   import sas_pkg::*;
   localparam int SEL_TIMEOUT = 200;
   logic        clock = 1'b0, rst = 1'b1, scriptStart = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb = 4'h1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        busyLineIn, busyLineOut, busyLineOe, selectIn, selectOut, selectOe;
   logic [15:0] dataLinesIn, dataLinesOut, dataLinesOe;
   logic        rivalArb = 1'b0, rivalSel = 1'b0, tgtOn = 1'b0;
   logic [7:0]  claims;
   int          bad_count = 0, checks = 0;
   always #2 clock = ~clock;
   sas_arb_sel #(.SEL_TIMEOUT(SEL_TIMEOUT)) DUT (
      .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .scriptStart, .busyLineIn, .busyLineOut, .busyLineOe, .selectIn, .selectOut, .selectOe,
      .dataLinesIn, .dataLinesOut, .dataLinesOe, .irq);
   sas_bus_model model (.clock, .rst, .rivalArb, .rivalSel, .tgtOn, .tgtId(4'h5),
      .busyLineOut, .busyLineOe, .selectOut, .selectOe, .dataLinesOut, .dataLinesOe,
      .busyLineIn, .selectIn, .dataLinesIn, .claims);
   // ----------
   // bus tasks and comparison
   // ----------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // aw and w offered together, each dropped once taken; only the watchdog ends a wait
   task automatic wr(input logic [11:0] idx, input logic [7:0] d);
      s_axi_awaddr <= idx << 2;
      s_axi_wdata <= {24'h0, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [11:0] idx);
      s_axi_araddr <= idx << 2;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
   endtask : rd
   task automatic rc(input string what, input logic [11:0] idx, input logic [31:0] exp);
      rd(idx);
      chk(what, rdv, exp);
   endtask : rc
   task automatic waitIrq;
      while (irq !== 1'b1) @(posedge clock);
   endtask : waitIrq
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   // ----------
   // tests
   // ----------
   // hang guard, some six times the expected run
   initial begin
      repeat (30000) @(posedge clock);
      bad_count++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rc("ctl0 reset", IDX_CTL0, {24'h0, CTL0_RESET});
      rc("ctl1 reset", IDX_CTL1, 32'h0);
      rd(12'h07f);
      chk("unmapped resp", resp, RESP_SLVERR);
      $display("test reset finished");
      wr(IDX_OWNID, 8'h03);
      wr(IDX_DESTID, 8'h05);
      wr(IDX_MASK0, 8'h40);
      {rivalArb, tgtOn} <= 2'h3;
      wr(IDX_CTL0, 8'he0);
      waitIrq();
      chk("irq done", irq, 1);
      chk("claims", claims, 2);
      rc("ist0", IDX_IST0, 32'h40);
      rd(IDX_STAT0);
      chk("won", rdv[STAT0_WON], 1);
      rc("ctl0 full", IDX_CTL0, 32'hc0);
      rc("ctl1 con", IDX_CTL1, 32'h10);
      wr(IDX_MASK0, 8'h00);
      chk("irq masked", irq, 0);
      wr(IDX_MASK0, 8'h40);
      chk("irq unmasked", irq, 1);
      wr(IDX_IST0, 8'h40);
      chk("irq cleared", irq, 0);
      {rivalArb, tgtOn} <= 2'h0;
      wr(IDX_CTL1, 8'h00);
      $display("test full win finished");
      wr(IDX_MASK1, 8'h04);
      scriptStart <= 1'b1;
      @(posedge clock);
      scriptStart <= 1'b0;
      waitIrq();
      rc("ist1", IDX_IST1, 32'h04);
      rc("ctl0 script", IDX_CTL0, 32'hc0);
      rc("ctl1 off", IDX_CTL1, 32'h0);
      wr(IDX_IST1, 8'h04);
      $display("test time-out finished");
      rivalSel <= 1'b1;
      wr(IDX_CTL0, 8'h20);
      repeat (100) @(posedge clock);
      chk("busy lost", busyLineOe, 0);
      rc("stat0 lost", IDX_STAT0, 32'h08);
      rc("ctl0 simple", IDX_CTL0, 32'h0);
      repeat (800) @(posedge clock);
      rivalSel <= 1'b0;
      wr(IDX_CTL0, 8'h20);
      repeat (ARB_DELAY_CYC + 50) @(posedge clock);
      rc("bus view", IDX_BUSVIEW, 32'h8);
      rc("ctl1 simple", IDX_CTL1, 32'h10);
      chk("own id", dataLinesOut & dataLinesOe, 16'h8);
      chk("busy held", busyLineOe, 1);
      wr(IDX_CTL1, 8'h00);
      chk("busy freed", busyLineOe, 0);
      $display("test simple finished");
      for (int m = 1; m < 3; m++) begin
         wr(IDX_CTL0, {m[1:0], 6'h20});
         repeat (20) @(posedge clock);
         chk("reserved bus", busyLineOe, 0);
         rc("reserved mode", IDX_CTL0, {24'h0, m[1:0], 6'h0});
      end
      $display("test reserved finished");
      conclude();
   end
endmodule : sas_arb_sel_tb
